// ### design/bnr_host_ctrl.sv
// Host controller that drives a bytewide nonvolatile RAM through its pins
`timescale 1ns/1ps
`default_nettype none
`include "bnr_cfg.svh"
module bnr_host_ctrl
  import bnr_pkg::*;
#(
  parameter int ADDR_W = `BNR_ADDR_W,
  parameter int DATA_W = `BNR_DATA_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clockEn,
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  output var  logic              reqReady,
  output var  logic              rspValid,
  output var  logic [DATA_W-1:0] rspRdata,
  output var  logic [ADDR_W-1:0] byteSelectLines,
  output var  logic              chipSelN,
  output var  logic              outEnN,
  output var  logic              writeStrobeN,
  input  wire logic [DATA_W-1:0] byteLanePinsIn,
  output var  logic [DATA_W-1:0] byteLanePinsOut,
  output var  logic              byteLanePinsOeN
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Only the documented geometry is served by the packed request type
  if (ADDR_W != `BNR_ADDR_W || DATA_W != `BNR_DATA_W)
    $error("bnr_host_ctrl supports only the 15-bit by 8-bit geometry");

  localparam int TW = 4;                                 // Timer width
  // Phase lengths must fit the timer and be at least one cycle
  if (`BNR_ACCESS_CYC < 1 || `BNR_PRECH_CYC < 1 || `BNR_ACCESS_CYC > 2**TW || `BNR_PRECH_CYC > 2**TW)
    $error("bnr_host_ctrl phase lengths do not fit the timer");
  localparam logic [TW-1:0] ACC_LOAD = TW'(`BNR_ACCESS_CYC - 1);
  localparam logic [TW-1:0] PRE_LOAD = TW'(`BNR_PRECH_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bnr_state_t  state;
    bnr_req_t    req;      // Request held for the whole cycle
    bnr_pins_t   pins;     // Registered pin drive
    logic        ready;
    logic        rspValid;
    logic [7:0]  rdata;
  } bnr_ctl_t;

  bnr_ctl_t cur;           // Registered state
  bnr_ctl_t next_cur;      // Next state
  logic     timerLoad;     // Starts a timed phase
  logic [TW-1:0] timerValue; // Phase length minus one
  logic     timerDone;     // Phase has elapsed

  bnr_cycle_timer #(.W(TW)) u_timer (
    .clock     (clock),
    .rst       (rst),
    .clockEn   (clockEn),
    .load      (timerLoad),
    .loadValue (timerValue),
    .done      (timerDone)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Every pin change is made on a clock edge so edges stay in our domain
  always_comb
  begin
    next_cur = cur;
    next_cur.rspValid = 1'b0;
    timerLoad = 1'b0;
    timerValue = ACC_LOAD;
    case (cur.state)
      BNR_IDLE:
      begin
        // Select idles high, so an access always starts with a falling edge
        next_cur.pins.ceN = 1'b1;
        if (reqValid && cur.ready)
        begin
          next_cur.req.write = reqWrite;
          next_cur.req.addr = reqAddr;
          next_cur.req.wdata = reqWdata;
          next_cur.ready = 1'b0;
          next_cur.state = BNR_SETUP;
        end
      end
      BNR_SETUP:
      begin
        // Address has been stable a cycle; drop select to latch it
        next_cur.pins.ceN = 1'b0;
        // Write: strobe falls one cycle after select, never with it
        next_cur.pins.oeN = cur.req.write;
        if (cur.req.write)
        begin
          next_cur.pins.dqOut = cur.req.wdata;
          next_cur.pins.dqOeN = 1'b0;
        end
        timerLoad = 1'b1;
        timerValue = ACC_LOAD;
        next_cur.state = cur.req.write ? BNR_STROBE : BNR_ACCESS;
      end
      BNR_STROBE:
      begin
        next_cur.pins.weN = 1'b0;
        next_cur.state = BNR_ACCESS;
      end
      BNR_ACCESS:
      begin
        // Hold the cycle for the full access time; never cut short
        if (timerDone)
        begin
          if (!cur.req.write)
          begin
            next_cur.rdata = byteLanePinsIn;
            next_cur.rspValid = 1'b1;
          end
          // Strobe rises together with select; it ends the write
          next_cur.pins.weN = 1'b1;
          next_cur.pins.ceN = 1'b1;
          next_cur.pins.oeN = 1'b1;
          timerLoad = 1'b1;
          timerValue = PRE_LOAD;
          next_cur.state = BNR_PRECH;
        end
      end
      BNR_PRECH:
      begin
        // Release bus one cycle after strobe rise, then precharge
        next_cur.pins.dqOeN = 1'b1;
        if (timerDone)
        begin
          // No polling: the next request is taken at once
          next_cur.ready = 1'b1;
          next_cur.state = BNR_IDLE;
        end
      end
      default:
        next_cur.state = BNR_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset parks select high, all strobes inactive, bus released
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.state <= BNR_IDLE;
      cur.pins.ceN <= 1'b1;
      cur.pins.oeN <= 1'b1;
      cur.pins.weN <= 1'b1;
      cur.pins.dqOeN <= 1'b1;
      cur.ready <= 1'b1;
    end
    else if (clockEn)
      cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  // Address follows the held request; it cannot move while select is low
  assign byteSelectLines = cur.req.addr;
  assign chipSelN        = cur.pins.ceN;
  assign outEnN          = cur.pins.oeN;
  assign writeStrobeN    = cur.pins.weN;
  assign byteLanePinsOut = cur.pins.dqOut;
  assign byteLanePinsOeN = cur.pins.dqOeN;
  assign reqReady        = cur.ready;
  assign rspValid        = cur.rspValid;
  assign rspRdata        = cur.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_selFall;
    $fell(chipSelN);
  endsequence

  property p_addrStable;
    @(posedge clock) disable iff (rst) !chipSelN && clockEn |-> $stable(byteSelectLines);
  endproperty
  a_addrStable: assert property (p_addrStable) else $error("address moved during select");

  property p_noContention;
    @(posedge clock) disable iff (rst) !outEnN |-> byteLanePinsOeN;
  endproperty
  a_noContention: assert property (p_noContention) else $error("bus driven with output enable");

  property p_weAfterCe;
    @(posedge clock) disable iff (rst) $fell(writeStrobeN) |-> !$past(chipSelN) && !chipSelN;
  endproperty
  a_weAfterCe: assert property (p_weAfterCe) else $error("strobe fell without select");

  property p_oeInWrite;
    @(posedge clock) disable iff (rst) !writeStrobeN |-> outEnN && !byteLanePinsOeN;
  endproperty
  a_oeInWrite: assert property (p_oeInWrite) else $error("write without driven bus");

  property p_precharge;
    @(posedge clock) disable iff (rst || !clockEn) $rose(chipSelN) |-> chipSelN[*3];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge too short");

  property p_access;
    @(posedge clock) disable iff (rst || !clockEn) s_selFall |-> !chipSelN[*3];
  endproperty
  a_access: assert property (p_access) else $error("access too short");

  property p_readRsp;
    @(posedge clock) disable iff (rst || !clockEn) s_selFall ##0 writeStrobeN ##1 writeStrobeN
      |-> ##[1:4] rspValid;
  endproperty
  a_readRsp: assert property (p_readRsp) else $error("read answer missing");

  property p_ready;
    @(posedge clock) disable iff (rst || !clockEn) $rose(chipSelN) |-> ##[1:4] reqReady;
  endproperty
  a_ready: assert property (p_ready) else $error("not ready after cycle");

  property p_selIdle;
    @(posedge clock) disable iff (rst) reqReady |-> chipSelN && writeStrobeN;
  endproperty
  a_selIdle: assert property (p_selIdle) else $error("select low while idle");
endmodule
`default_nettype wire

// ### common/bnr_cfg.svh
// Constants of the bytewide nonvolatile RAM host controller
`ifndef BNR_CFG_SVH
`define BNR_CFG_SVH
// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define BNR_ADDR_W      15
`define BNR_DATA_W      8
`define BNR_BLOCK_MSB_W 5
// ----------------------------------------------------------------
// Timing (ns) and clock
// ----------------------------------------------------------------
`define BNR_CLK_NS      25
`define BNR_ACCESS_NS   70
`define BNR_CYCLE_NS    130
// Least times round up to whole cycles
`define BNR_ACCESS_CYC  ((`BNR_ACCESS_NS + `BNR_CLK_NS - 1) / `BNR_CLK_NS)
`define BNR_PRECH_CYC   (((`BNR_CYCLE_NS - `BNR_ACCESS_NS) + `BNR_CLK_NS - 1) / `BNR_CLK_NS)
// Address setup before select falls, in cycles
`define BNR_SETUP_CYC   1
`endif

// ### common/bnr_pkg.sv
// Types of the bytewide nonvolatile RAM host controller
`default_nettype none
package bnr_pkg;
  typedef enum logic [2:0] {BNR_IDLE, BNR_SETUP, BNR_ACCESS, BNR_STROBE, BNR_PRECH} bnr_state_t;
  typedef struct packed {
    logic        write;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } bnr_req_t;
  typedef struct packed {
    logic       ceN;
    logic       oeN;
    logic       weN;
    logic [7:0] dqOut;
    logic       dqOeN;
  } bnr_pins_t;
endpackage
`default_nettype wire

// ### design/bnr_cycle_timer.sv
// Down counter that times the access and precharge phases of a memory cycle
`timescale 1ns/1ps
`default_nettype none
module bnr_cycle_timer #(
  parameter int W = 4
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         clockEn,
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  output var  logic         done
);
  // A zero-width counter cannot time anything
  if (W < 1)
    $error("bnr_cycle_timer needs a width of at least one bit");

  logic [W-1:0] count;   // Cycles left in the phase
  logic [W-1:0] next_count;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Load has priority so a phase can restart back to back
  always_comb
  begin
    next_count = count;
    if (load)
      next_count = loadValue;
    else if (count != '0)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      count <= '0;
    else if (clockEn)
      count <= next_count;
  end

  assign done = (count == '0);
endmodule
`default_nettype wire

// ### dv/bnr_ram_model.sv
// Clocked behavioural model of the bytewide nonvolatile RAM, with bus resolution
`timescale 1ns/1ps
`default_nettype none
`include "bnr_cfg.svh"
module bnr_ram_model (
  input  wire logic        clock,
  input  wire logic [14:0] byteSelectLines,
  input  wire logic        chipSelN,
  input  wire logic        outEnN,
  input  wire logic        writeStrobeN,
  input  wire logic [7:0]  hostData,
  input  wire logic        hostOeN,
  output var  logic [7:0]  bus,
  output var  int          protoErr
);
  // ----------------------------------------------------------------
  // Array and latches
  // ----------------------------------------------------------------
  logic [7:0]  mem [32768];     // Plain index, block bits included
  logic [14:0] latAddr;         // Address taken at select fall
  logic        ceQ    = 1'b1;   // Select seen at last edge
  logic        weQ    = 1'b1;   // Strobe seen at last edge
  logic        wrCyc  = 1'b0;   // Cycle has turned into a write
  logic        wrOpen = 1'b0;   // Write access still running
  logic [7:0]  lastBus = 8'h00; // Released bus shows its inverse
  int          accCnt = 0;      // Edges since select fall
  int          preCnt = 100;    // Edges with select high
  int          errCnt = 0;      // Host protocol faults seen
  logic        devDrive;
  logic        ceFall;
  assign protoErr = errCnt;
  assign ceFall = ceQ && !chipSelN;
  // Drive only in a read once access time is over; never kinder
  // The fall is only seen on the edge after it, so the count trails the pin by one edge
  assign devDrive = !chipSelN && !outEnN && !wrCyc && accCnt >= `BNR_ACCESS_CYC - 1;
  // Wire level from both parties' enables
  always_comb
  begin
    if (!hostOeN)
      bus = hostData;
    else if (devDrive)
      bus = mem[latAddr];
    else
      bus = ~lastBus;
  end
  // Edge detection in the clock domain
  always @(posedge clock)
  begin
    lastBus <= bus;
    ceQ <= chipSelN;
    weQ <= writeStrobeN;
    preCnt <= chipSelN ? preCnt + 1 : 0;
    errCnt <= errCnt + int'(!hostOeN && devDrive) + int'(ceFall && preCnt < `BNR_PRECH_CYC);
    if (ceFall)
    begin
      latAddr <= byteSelectLines;
      wrCyc <= !writeStrobeN;
      wrOpen <= !writeStrobeN;
      accCnt <= 1;
    end
    else if (!chipSelN)
    begin
      accCnt <= accCnt + 1;
      if (weQ && !writeStrobeN)
      begin
        wrCyc <= 1'b1;
        wrOpen <= 1'b1;
      end
    end
    else
      accCnt <= 0;       // Stale count must not let the next fall drive early
    // First rise of strobe or select ends the write, even if early
    if (wrOpen && !ceFall && (writeStrobeN || chipSelN))
    begin
      mem[latAddr] <= bus;
      wrOpen <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_bytewide_nonvolatile_ram_port.sv
// Self-checking bench of the host controller against the device model
`timescale 1ns/1ps
`default_nettype none
module tb_bytewide_nonvolatile_ram_port;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        clockEn = 1'b1;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [14:0] reqAddr = 15'h0000;
  logic [7:0]  reqWdata = 8'h00;
  logic [14:0] addrPins;
  logic [7:0]  rspRdata, hostData, bus, rd;
  logic        reqReady, rspValid, ceN, oeN, weN, hostOeN;
  int          err_total = 0;
  int          checks_done = 0;
  int          protoErr;
  // Block bits 14:10 vary so aliasing shows
  localparam logic [14:0] ADDRS [6] = '{15'h0000, 15'h7fff, 15'h0400, 15'h7c00, 15'h4000, 15'h2aaa};
  always #12.5 clock = ~clock;
  bnr_host_ctrl dut (.clock(clock), .rst(rst), .clockEn(clockEn), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
    .byteSelectLines(addrPins), .chipSelN(ceN), .outEnN(oeN), .writeStrobeN(weN),
    .byteLanePinsIn(bus), .byteLanePinsOut(hostData), .byteLanePinsOeN(hostOeN));
  bnr_ram_model mdl (.clock(clock), .byteSelectLines(addrPins), .chipSelN(ceN), .outEnN(oeN),
    .writeStrobeN(weN), .hostData(hostData), .hostOeN(hostOeN), .bus(bus), .protoErr(protoErr));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    check(protoErr, 0);
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One request, counted in enabled cycles; clock enable dropped at cycle frz
  task automatic do_op(input logic wr, input logic [14:0] a, input logic [7:0] d, input int frz);
    int n;
    logic [2:0] pins;
    n = 1;
    rd = 8'hxx;
    @(negedge clock);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    while (reqReady !== 1'b1)
      @(negedge clock);
    @(negedge clock);
    reqValid = 1'b0;
    while (reqReady !== 1'b1 && n < 20)
    begin
      if (rspValid === 1'b1)
      begin
        rd = rspRdata;
        check(n, 5);
      end
      if (n == frz)
      begin
        pins = {ceN, oeN, weN};
        clockEn = 1'b0;
        repeat (3) @(negedge clock);
        check(pins, {ceN, oeN, weN});
        clockEn = 1'b1;
      end
      @(negedge clock);
      n++;
    end
    check(n, 8);
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e, input int frz);
    do_op(1'b0, a, 8'h00, frz);
    check(rd, e);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset lands in mid-write; pins must go idle at once
  task automatic t_abort;
    @(negedge clock);
    reqValid = 1'b1;
    reqWrite = 1'b1;
    reqAddr = 15'h0555;
    reqWdata = 8'h0f;
    @(negedge clock);
    reqValid = 1'b0;
    repeat (3) @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    check({ceN, oeN, weN, hostOeN, reqReady}, 5'h1f);
    rst = 1'b0;
    do_op(1'b1, 15'h0777, 8'h96, 0);
    rd_chk(15'h0777, 8'h96, 0);
    rd_chk(15'h0000, 8'h11, 0);
  endtask
  initial
  begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    check({ceN, oeN, weN, hostOeN, reqReady, rspValid, addrPins}, {6'h3e, 15'h0000});
    foreach (ADDRS[i])
      do_op(1'b1, ADDRS[i], 8'(8'h11 * (i + 1)), 0);
    foreach (ADDRS[i])
      rd_chk(ADDRS[i], 8'(8'h11 * (i + 1)), 0);
    do_op(1'b1, 15'h1234, 8'hc3, 3);
    rd_chk(15'h1234, 8'hc3, 4);
    t_abort();
    test_done();
  end
  // Hang guard, far beyond the fewer than two hundred cycles the run needs
  initial
  begin
    #(25 * 4000);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
